/* include/ddp_cfg.svh */
// How it works
// - Sample inputs at true-rise, complement-fall crossing
// - Read data changes on both clock crossings
// - CKE high runs clocks, buffers, drivers
// - CKE low: idle gives precharge/self, open gives active
// - Edge-sampled entries; self refresh exits without clock
// - Power-down keeps only clock, ODT, CKE buffers
// - Self refresh keeps only the CKE buffer
// - Chip select high masks the command
// - Command decoded from CS, RAS, CAS, WE
// - ODT terminates only data, strobe, mask pins
// - ODT ignored when extended mode disables it
// - DM-high write beats are dropped except in RDQS mode
// - Mask sampled on both strobe edges
// - Extended mode picks mask or read strobe
// - Bank inputs select the command's bank
// - Bank inputs pick mode or extended register
// - Row on activate; column, auto-precharge on access
// - A10 high precharges all, else one bank
// - Mode set loads op-code from address
// - Read strobe edge-aligned; write strobe centred
// - EMR bit 10 zero selects differential strobes
`ifndef DDP_CFG_SVH
`define DDP_CFG_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define DDP_ADDR_W     14
`define DDP_BA_W       2
`define DDP_COL_W      10
`define DDP_DQ_W       8
`define DDP_NBANK      4

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DDP_AP_BIT       10
`define DDP_EMR_SE_BIT   10
`define DDP_EMR_RDQS_BIT 11
`define DDP_EMR_RTT0_BIT 2
`define DDP_EMR_RTT1_BIT 6

// ---------------------------------------------------------------
// Command codes {cs_n, ras_n, cas_n, we_n}
// ---------------------------------------------------------------
`define DDP_CODE_MRS   4'h0
`define DDP_CODE_REF   4'h1
`define DDP_CODE_PRE   4'h2
`define DDP_CODE_ACT   4'h3
`define DDP_CODE_WR    4'h4
`define DDP_CODE_RD    4'h5
`define DDP_CODE_NOP   4'h7

// ---------------------------------------------------------------
// Register selects and counts
// ---------------------------------------------------------------
`define DDP_SEL_MR     2'h0
`define DDP_SEL_EMR    2'h1
`define DDP_BANKS_ALL  4'hF
`define DDP_NO_BANKS   4'h0
`define DDP_BURST      4'h4
`define DDP_CNT_ZERO   4'h0
`define DDP_CNT_ONE    4'h1

`endif

/* include/ddp_dec_if.sv */
`timescale 1ns/1ps
`include "ddp_cfg.svh"

interface ddp_dec_if;
  import ddp_pkg::*;
  logic                  en;
  logic [3:0]            code;
  logic [`DDP_BA_W-1:0]   ba;
  logic [`DDP_ADDR_W-1:0] addr;
  ddp_cmd_t              cmd;
  logic [`DDP_NBANK-1:0]  bank_hot;
  logic [`DDP_NBANK-1:0]  pre_mask;
  logic                  auto_pre;
  logic                  sel_mr;
  logic                  sel_emr;

  modport dec (
    input  en, code, ba, addr,
    output cmd, bank_hot, pre_mask, auto_pre, sel_mr, sel_emr
  );
  modport use_side (
    output en, code, ba, addr,
    input  cmd, bank_hot, pre_mask, auto_pre, sel_mr, sel_emr
  );
endinterface : ddp_dec_if

/* include/ddp_pkg.sv */
`include "ddp_cfg.svh"

package ddp_pkg;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_PRE_PD,
    PWR_ACT_PD,
    PWR_SELF_REF
  } ddp_pwr_t;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_NOP,
    CMD_MRS,
    CMD_REF,
    CMD_PRE,
    CMD_ACT,
    CMD_WR,
    CMD_RD
  } ddp_cmd_t;

  typedef struct packed {
    logic                  ck;
    logic                  ck_n;
    logic                  cke;
    logic                  cs_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic                  odt;
    logic [`DDP_BA_W-1:0]   ba;
    logic [`DDP_ADDR_W-1:0] addr;
    logic                  dqs;
    logic                  dm;
    logic [`DDP_DQ_W-1:0]   dq;
  } ddp_pins_t;

  typedef struct packed {
    ddp_pins_t              s1;
    ddp_pins_t              s2;
    logic                   ckx_prev;
    logic                   dqs_prev;
    logic                   cke_q;
    ddp_pwr_t               pwr;
    logic [`DDP_NBANK-1:0]   open_banks;
    logic [`DDP_ADDR_W-1:0]  mr;
    logic [`DDP_ADDR_W-1:0]  emr;
    logic                   odt_q;
    logic                   cmd_v;
    logic [3:0]             code;
    logic [`DDP_BA_W-1:0]    bank;
    logic [`DDP_ADDR_W-1:0]  row;
    logic [`DDP_COL_W-1:0]   col;
    logic                   auto_pre;
    logic [3:0]             wr_left;
    logic [3:0]             rd_left;
    logic                   wr_beat;
    logic                   wr_we;
    logic [`DDP_DQ_W-1:0]    wr_data;
    logic                   rd_req;
    logic                   rd_dqs;
    logic [`DDP_DQ_W-1:0]    dq_out;
    logic                   dq_oe;
  } ddp_state_t;

  function automatic logic [`DDP_NBANK-1:0] ddp_bank_hot(
    input logic [`DDP_BA_W-1:0] ba
  );
    ddp_bank_hot = `DDP_NBANK'(1) << ba;
  endfunction : ddp_bank_hot

endpackage : ddp_pkg

/* sim/ddp_ctrl_model.sv */
`timescale 1ns/1ps
`include "ddp_cfg.svh"

module ddp_ctrl_model (
  input  wire logic        i_clk,
  output      logic        o_ck,
  output      logic        o_ck_n,
  output      logic        o_cke,
  output      logic [3:0]  o_code,
  output      logic [1:0]  o_ba,
  output      logic [13:0] o_addr,
  output      logic        o_dqs,
  output      logic        o_dm,
  output      logic [7:0]  o_dq
);
  logic ck_run;

  // ------------------------------------------------------------
  // Link clock, parks low when stopped
  // ------------------------------------------------------------
  assign o_ck_n = ~o_ck;

  initial
  begin
    ck_run = 1'b1;
    o_cke = 1'b1;
    o_code = 4'hF;
    o_ba = 2'h0;
    o_addr = 14'h0000;
    o_dqs = 1'b0;
    o_dm = 1'b0;
    o_dq = 8'h00;
    o_ck = 1'b0;
    #3.3;
    forever
    begin
      #80;
      if (ck_run || o_ck)
        o_ck = ~o_ck;
    end
  end

  // ------------------------------------------------------------
  // Controller actions
  // ------------------------------------------------------------
  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                     input logic [13:0] a, input logic k);
    @(negedge o_ck);
    @(posedge i_clk);
    o_code <= c;
    o_ba <= b;
    o_addr <= a;
    o_cke <= k;
    @(posedge o_ck);
    @(negedge o_ck);
    @(posedge i_clk);
    o_code <= 4'hF;
    o_addr <= ~a;
    o_dq <= ~o_dq;
  endtask : cmd

  task automatic wbeat(input logic [7:0] d, input logic m);
    @(posedge i_clk);
    o_dq <= d;
    o_dm <= m;
    repeat (2) @(posedge i_clk);
    o_dqs <= ~o_dqs;
    repeat (3) @(posedge i_clk);
  endtask : wbeat

  task automatic wake();
    ck_run = 1'b0;
    repeat (40) @(posedge i_clk);
    o_cke <= 1'b1;
    repeat (10) @(posedge i_clk);
  endtask : wake
endmodule : ddp_ctrl_model

/* sim/testbench.sv */
`timescale 1ns/1ps
`include "ddp_cfg.svh"

module testbench;
  import ddp_pkg::*;
  logic        clk, rst_n, odt, ck, ck_n, cke, dqs, dm;
  logic [3:0]  code, o_code;
  logic [1:0]  ba, o_bank, o_pwr;
  logic [13:0] addr, r, o_row, o_mr, o_emr;
  logic [7:0]  dq, rd_data, rd_prev, o_dq, o_wdata;
  logic [9:0]  o_col;
  logic [3:0]  o_open;
  logic        o_rd_req, o_wbeat, o_we, o_valid, o_ap, o_run;
  logic        o_cmd_en, o_ck_en, o_term, o_rdqs, o_diff;
  logic        o_dqs, o_dqs_oe, o_dqs_n, o_dqs_n_oe, o_dq_oe;
  logic [8:0]  wq[$];
  logic [8:0]  w;
  integer      n_errors, comparisons, seed, n_valid, n_rd;
  integer      open, mr, emr, i;

  ddp_ctrl_model u_ddp_ctrl_model (.i_clk(clk), .o_ck(ck),
    .o_ck_n(ck_n), .o_cke(cke), .o_code(code), .o_ba(ba),
    .o_addr(addr), .o_dqs(dqs), .o_dm(dm), .o_dq(dq));

  ddp_top u_ddp_top (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_CK(ck),
    .I_CK_N(ck_n), .I_CKE(cke), .I_CS_N(code[3]), .I_RAS_N(code[2]),
    .I_CAS_N(code[1]), .I_WE_N(code[0]), .I_ODT(odt), .I_BA(ba),
    .I_ADDR(addr), .I_DM(dm), .I_DQS(dqs), .O_DQS(o_dqs),
    .O_DQS_OE(o_dqs_oe), .O_DQS_N(o_dqs_n), .O_DQS_N_OE(o_dqs_n_oe),
    .I_DQ(dq), .O_DQ(o_dq), .O_DQ_OE(o_dq_oe),
    .I_RD_DATA(rd_data), .O_RD_REQ(o_rd_req), .O_WR_BEAT(o_wbeat),
    .O_WR_WE(o_we), .O_WR_DATA(o_wdata), .O_CMD_VALID(o_valid),
    .O_CMD_CODE(o_code), .O_BANK(o_bank), .O_ROW(o_row),
    .O_COL(o_col), .O_AUTO_PRE(o_ap), .O_OPEN_BANKS(o_open),
    .O_PWR_STATE(o_pwr), .O_CLK_RUN(o_run), .O_IBUF_CMD_EN(o_cmd_en),
    .O_IBUF_CK_EN(o_ck_en), .O_TERM_EN(o_term), .O_DM_IS_RDQS(o_rdqs),
    .O_DQS_DIFF(o_diff), .O_MODE_REG(o_mr), .O_EXT_MODE_REG(o_emr));

  // ------------------------------------------------------------
  // Checking and model
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("Checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic pwr(input integer st);
    check("power", o_pwr, st);
    check("enables", {o_run, o_cmd_en, o_ck_en},
          {st == 0, st == 0, st != 3});
  endtask : pwr

  task automatic run(input logic [3:0] c, input logic [1:0] b,
                     input logic [13:0] a, input logic k, input logic v);
    integer nv;
    nv = n_valid;
    u_ddp_ctrl_model.cmd(c, b, a, k);
    check("accepted", n_valid - nv, v);
    if (v)
    begin
      check("code", o_code, c);
      check("bank", o_bank, b);
      check("row", o_row, a);
      case (c)
        `DDP_CODE_ACT: open = open | (1 << b);
        `DDP_CODE_PRE: open = a[10] ? 0 : open & ~(1 << b);
        `DDP_CODE_MRS: if (b == 0) mr = a; else if (b == 1) emr = a;
        default:
        begin
          check("column", {o_ap, o_col}, a[10:0]);
          if (a[10])
            open = open & ~(1 << b);
        end
      endcase
      check("open", o_open, open);
      check("mode", o_mr, mr);
      check("ext mode", o_emr, emr);
      check("strobe", {o_rdqs, o_diff}, {emr[11], ~emr[10]});
      check("term", o_term, odt & (emr[2] | emr[6]));
    end
  endtask : run

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (o_valid === 1'b1)
      n_valid++;
    if (o_rd_req === 1'b1)
    begin
      n_rd++;
      check("read data", o_dq, rd_prev);
      check("read strobe", {o_dq_oe, o_dqs_oe, o_dqs_n_oe, o_dqs, o_dqs_n},
            {2'h3, ~emr[10], ~n_rd[0], n_rd[0]});
    end
    if (o_wbeat === 1'b1 && wq.size() == 0)
      check("spare beat", 1, 0);
    else if (o_wbeat === 1'b1)
    begin
      w = wq.pop_front();
      check("write", {o_we, o_wdata}, {~w[8], w[7:0]});
    end
    rd_prev = rd_data;
    rd_data <= 8'($random(seed));
  end

  initial
  begin
    #200000;
    n_errors++;
    stop_test();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    {rst_n, odt, n_errors, comparisons, n_valid, n_rd} = '0;
    {rd_data, rd_prev, open, mr, emr} = '0;
    seed = 32'hf3225993;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("reset", {o_open, o_diff, o_mr}, 19'h04000);
    pwr(0);
    run(4'hF, 2'h0, 14'h0000, 1'b1, 1'b0);
    for (i = 0; i < 4; i++)
      run(`DDP_CODE_MRS, i[1:0], 14'($random(seed)), 1'b1, 1'b1);
    odt <= 1'b1;
    for (i = 0; i < 3; i++)
      run(`DDP_CODE_MRS, 2'h1, (i == 1) ? 14'h0000 : 14'h0004 << (i * 2),
          1'b1, 1'b1);
    odt <= 1'b0;
    run(`DDP_CODE_MRS, 2'h1, 14'h0004, 1'b1, 1'b1);
    for (i = 0; i < 4; i++)
      run(`DDP_CODE_ACT, i[1:0], 14'($random(seed)), 1'b1, 1'b1);
    run(4'hB, 2'h1, 14'h0000, 1'b1, 1'b0);
    run(`DDP_CODE_PRE, 2'h1, 14'h0000, 1'b1, 1'b1);
    n_rd = 0;
    r = 14'($random(seed));
    run(`DDP_CODE_RD, 2'h2, r & 14'h3BFF, 1'b1, 1'b1);
    run(4'hF, 2'h0, 14'h0000, 1'b1, 1'b0);
    check("beats", n_rd, 4);
    run(`DDP_CODE_WR, 2'h3, r | 14'h0400, 1'b1, 1'b1);
    for (i = 0; i < 5; i++)
    begin
      r = 14'($random(seed));
      if (i < 4)
        wq.push_back(r[8:0]);
      u_ddp_ctrl_model.wbeat(r[7:0], r[8]);
    end
    check("left", wq.size(), 0);
    check("bus off", {o_dq_oe, o_dqs_oe, o_dqs_n_oe}, 3'h0);
    run(4'hF, 2'h0, 14'h0000, 1'b0, 1'b0);
    pwr(2);
    run(`DDP_CODE_ACT, 2'h1, 14'h0000, 1'b0, 1'b0);
    run(4'hF, 2'h0, 14'h0000, 1'b1, 1'b0);
    pwr(0);
    run(4'hF, 2'h0, 14'h0000, 1'b1, 1'b0);
    run(`DDP_CODE_PRE, 2'h0, 14'h0400, 1'b1, 1'b1);
    run(`DDP_CODE_REF, 2'h0, 14'h0000, 1'b1, 1'b1);
    run(4'hF, 2'h0, 14'h0000, 1'b0, 1'b0);
    pwr(1);
    run(4'hF, 2'h0, 14'h0000, 1'b1, 1'b0);
    pwr(0);
    run(4'hF, 2'h0, 14'h0000, 1'b1, 1'b0);
    run(`DDP_CODE_REF, 2'h0, 14'h0000, 1'b0, 1'b0);
    pwr(3);
    u_ddp_ctrl_model.wake();
    pwr(0);
    u_ddp_ctrl_model.ck_run = 1'b1;
    run(4'hF, 2'h0, 14'h0000, 1'b1, 1'b0);
    run(`DDP_CODE_ACT, 2'h2, 14'h1234, 1'b1, 1'b1);
    stop_test();
  end
endmodule : testbench

/* src/ddp_cmd_dec.sv */
`timescale 1ns/1ps
`include "ddp_cfg.svh"

module ddp_cmd_dec
  import ddp_pkg::*;
(
  ddp_dec_if.dec d
);

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  always_comb
  begin
    d.cmd = CMD_NONE;
    if (d.en)
    begin
      case (d.code)
        `DDP_CODE_MRS: d.cmd = CMD_MRS;
        `DDP_CODE_REF: d.cmd = CMD_REF;
        `DDP_CODE_PRE: d.cmd = CMD_PRE;
        `DDP_CODE_ACT: d.cmd = CMD_ACT;
        `DDP_CODE_WR:  d.cmd = CMD_WR;
        `DDP_CODE_RD:  d.cmd = CMD_RD;
        `DDP_CODE_NOP: d.cmd = CMD_NOP;
        default:       d.cmd = CMD_NONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bank and address fields
  // ---------------------------------------------------------------
  assign d.bank_hot = ddp_bank_hot(d.ba);
  assign d.auto_pre = d.addr[`DDP_AP_BIT];
  assign d.pre_mask = d.addr[`DDP_AP_BIT] ? `DDP_BANKS_ALL
                                          : ddp_bank_hot(d.ba);
  assign d.sel_mr   = (d.ba == `DDP_SEL_MR);
  assign d.sel_emr  = (d.ba == `DDP_SEL_EMR);

endmodule : ddp_cmd_dec

/* src/ddp_top.sv */
`timescale 1ns/1ps
`include "ddp_cfg.svh"

module ddp_top
  import ddp_pkg::*;
(
  input  wire logic                   I_CLK_SYS,
  input  wire logic                   I_RESET_N,
  input  wire logic                   I_CK,
  input  wire logic                   I_CK_N,
  input  wire logic                   I_CKE,
  input  wire logic                   I_CS_N,
  input  wire logic                   I_RAS_N,
  input  wire logic                   I_CAS_N,
  input  wire logic                   I_WE_N,
  input  wire logic                   I_ODT,
  input  wire logic [`DDP_BA_W-1:0]   I_BA,
  input  wire logic [`DDP_ADDR_W-1:0] I_ADDR,
  input  wire logic                   I_DM,
  input  wire logic                   I_DQS,
  output      logic                   O_DQS,
  output      logic                   O_DQS_OE,
  output      logic                   O_DQS_N,
  output      logic                   O_DQS_N_OE,
  input  wire logic [`DDP_DQ_W-1:0]   I_DQ,
  output      logic [`DDP_DQ_W-1:0]   O_DQ,
  output      logic                   O_DQ_OE,
  input  wire logic [`DDP_DQ_W-1:0]   I_RD_DATA,
  output      logic                   O_RD_REQ,
  output      logic                   O_WR_BEAT,
  output      logic                   O_WR_WE,
  output      logic [`DDP_DQ_W-1:0]   O_WR_DATA,
  output      logic                   O_CMD_VALID,
  output      logic [3:0]             O_CMD_CODE,
  output      logic [`DDP_BA_W-1:0]   O_BANK,
  output      logic [`DDP_ADDR_W-1:0] O_ROW,
  output      logic [`DDP_COL_W-1:0]  O_COL,
  output      logic                   O_AUTO_PRE,
  output      logic [`DDP_NBANK-1:0]  O_OPEN_BANKS,
  output      logic [1:0]             O_PWR_STATE,
  output      logic                   O_CLK_RUN,
  output      logic                   O_IBUF_CMD_EN,
  output      logic                   O_IBUF_CK_EN,
  output      logic                   O_TERM_EN,
  output      logic                   O_DM_IS_RDQS,
  output      logic                   O_DQS_DIFF,
  output      logic [`DDP_ADDR_W-1:0] O_MODE_REG,
  output      logic [`DDP_ADDR_W-1:0] O_EXT_MODE_REG
);

  // ---------------------------------------------------------------
  // State and pin capture
  // ---------------------------------------------------------------
  ddp_state_t st;
  ddp_state_t next_st;
  ddp_pins_t  pins;
  logic       ckx;
  logic       ck_rise;
  logic       ck_fall;
  logic       dqs_edge;
  logic       rtt_on;
  logic       rdqs_mode;

  ddp_dec_if dec_if ();

  ddp_cmd_dec u_dec (
    .d (dec_if)
  );

  always_comb
  begin
    pins       = '0;
    pins.ck    = I_CK;
    pins.ck_n  = I_CK_N;
    pins.cke   = I_CKE;
    pins.cs_n  = I_CS_N;
    pins.ras_n = I_RAS_N;
    pins.cas_n = I_CAS_N;
    pins.we_n  = I_WE_N;
    pins.odt   = I_ODT;
    pins.ba    = I_BA;
    pins.addr  = I_ADDR;
    pins.dqs   = I_DQS;
    pins.dm    = I_DM;
    pins.dq    = I_DQ;
  end

  // ---------------------------------------------------------------
  // Clock crossing detect
  // ---------------------------------------------------------------
  assign ckx       = st.s2.ck & ~st.s2.ck_n;
  assign ck_rise   = ckx & ~st.ckx_prev;
  assign ck_fall   = ~ckx & st.ckx_prev;
  assign dqs_edge  = st.s2.dqs ^ st.dqs_prev;
  assign rtt_on    = st.emr[`DDP_EMR_RTT0_BIT] |
                     st.emr[`DDP_EMR_RTT1_BIT];
  assign rdqs_mode = st.emr[`DDP_EMR_RDQS_BIT];

  assign dec_if.en   = (st.pwr == PWR_ACTIVE) & ck_rise & st.s2.cke;
  assign dec_if.code = {st.s2.cs_n, st.s2.ras_n, st.s2.cas_n,
                        st.s2.we_n};
  assign dec_if.ba   = st.s2.ba;
  assign dec_if.addr = st.s2.addr;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st          = st;
    next_st.s1       = pins;
    next_st.s2       = st.s1;
    next_st.ckx_prev = ckx;
    next_st.dqs_prev = st.s2.dqs;
    next_st.cmd_v    = 1'b0;
    next_st.wr_beat  = 1'b0;
    next_st.wr_we    = 1'b0;
    next_st.rd_req   = 1'b0;
    case (st.pwr)
      PWR_ACTIVE:
      begin
        if (ck_rise)
        begin
          next_st.cke_q = st.s2.cke;
          if (st.cke_q && !st.s2.cke)
          begin
            if (st.open_banks != `DDP_NO_BANKS)
              next_st.pwr = PWR_ACT_PD;
            else if (st.s2.cs_n == 1'b0 &&
                     dec_if.code == `DDP_CODE_REF)
              next_st.pwr = PWR_SELF_REF;
            else
              next_st.pwr = PWR_PRE_PD;
            next_st.rd_left = `DDP_CNT_ZERO;
            next_st.wr_left = `DDP_CNT_ZERO;
            next_st.dq_oe   = 1'b0;
          end
          else if (st.cke_q && dec_if.cmd != CMD_NONE)
          begin
            next_st.cmd_v    = 1'b1;
            next_st.code     = dec_if.code;
            next_st.bank     = st.s2.ba;
            next_st.row      = st.s2.addr;
            next_st.col      = st.s2.addr[`DDP_COL_W-1:0];
            next_st.auto_pre = dec_if.auto_pre;
            case (dec_if.cmd)
              CMD_ACT:
                next_st.open_banks = st.open_banks |
                                     dec_if.bank_hot;
              CMD_PRE:
                next_st.open_banks = st.open_banks &
                                     ~dec_if.pre_mask;
              CMD_RD:
              begin
                next_st.rd_left = `DDP_BURST;
                if (dec_if.auto_pre)
                  next_st.open_banks = st.open_banks &
                                       ~dec_if.bank_hot;
              end
              CMD_WR:
              begin
                next_st.wr_left = `DDP_BURST;
                if (dec_if.auto_pre)
                  next_st.open_banks = st.open_banks &
                                       ~dec_if.bank_hot;
              end
              CMD_MRS:
              begin
                if (dec_if.sel_mr)
                  next_st.mr = st.s2.addr;
                else if (dec_if.sel_emr)
                  next_st.emr = st.s2.addr;
              end
              default:
                next_st.open_banks = st.open_banks;
            endcase
          end
        end
        // Read beats on both crossings, strobe edge-aligned
        if ((ck_rise || ck_fall) && st.pwr == PWR_ACTIVE)
        begin
          if (st.rd_left != `DDP_CNT_ZERO && next_st.pwr == PWR_ACTIVE)
          begin
            next_st.dq_out  = I_RD_DATA;
            next_st.rd_dqs  = ckx;
            next_st.dq_oe   = 1'b1;
            next_st.rd_req  = 1'b1;
            next_st.rd_left = st.rd_left - `DDP_CNT_ONE;
          end
          else if (st.rd_left == `DDP_CNT_ZERO)
          begin
            next_st.dq_oe  = 1'b0;
            next_st.rd_dqs = 1'b0;
          end
        end
        // Write beats on both strobe edges
        if (dqs_edge && st.wr_left != `DDP_CNT_ZERO &&
            next_st.pwr == PWR_ACTIVE)
        begin
          next_st.wr_beat = 1'b1;
          next_st.wr_data = st.s2.dq;
          next_st.wr_we   = ~(st.s2.dm & ~rdqs_mode);
          next_st.wr_left = st.wr_left - `DDP_CNT_ONE;
        end
      end
      PWR_PRE_PD, PWR_ACT_PD:
      begin
        if (ck_rise && st.s2.cke)
        begin
          next_st.pwr   = PWR_ACTIVE;
          next_st.cke_q = 1'b1;
        end
      end
      PWR_SELF_REF:
      begin
        if (st.s2.cke)
        begin
          next_st.pwr   = PWR_ACTIVE;
          next_st.cke_q = 1'b1;
        end
      end
      default:
        next_st.pwr = PWR_ACTIVE;
    endcase
    // Termination control sampled except in self refresh
    if (st.pwr == PWR_SELF_REF)
      next_st.odt_q = 1'b0;
    else if (ck_rise)
      next_st.odt_q = st.s2.odt;
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RESET_N)
      st <= '0;
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign O_DQ           = st.dq_out;
  assign O_DQ_OE        = st.dq_oe;
  assign O_DQS          = st.rd_dqs;
  assign O_DQS_OE       = st.dq_oe;
  assign O_DQS_N        = ~st.rd_dqs;
  assign O_DQS_N_OE     = st.dq_oe & ~st.emr[`DDP_EMR_SE_BIT];
  assign O_RD_REQ       = st.rd_req;
  assign O_WR_BEAT      = st.wr_beat;
  assign O_WR_WE        = st.wr_we;
  assign O_WR_DATA      = st.wr_data;
  assign O_CMD_VALID    = st.cmd_v;
  assign O_CMD_CODE     = st.code;
  assign O_BANK         = st.bank;
  assign O_ROW          = st.row;
  assign O_COL          = st.col;
  assign O_AUTO_PRE     = st.auto_pre;
  assign O_OPEN_BANKS   = st.open_banks;
  assign O_PWR_STATE    = st.pwr;
  assign O_CLK_RUN      = (st.pwr == PWR_ACTIVE);
  assign O_IBUF_CMD_EN  = (st.pwr == PWR_ACTIVE);
  assign O_IBUF_CK_EN   = (st.pwr != PWR_SELF_REF);
  assign O_TERM_EN      = st.odt_q & rtt_on &
                          (st.pwr != PWR_SELF_REF);
  assign O_DM_IS_RDQS   = rdqs_mode;
  assign O_DQS_DIFF     = ~st.emr[`DDP_EMR_SE_BIT];
  assign O_MODE_REG     = st.mr;
  assign O_EXT_MODE_REG = st.emr;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESET_N);

  a_cmd_on_rise: assert property (
    st.cmd_v |-> $past(ckx) && !$past(st.ckx_prev))
    else $error("command taken off a rising crossing");
  a_cs_masks_cmd: assert property (
    st.cmd_v |-> !$past(st.s2.cs_n))
    else $error("command taken with chip select high");
  a_drv_off_low: assert property (
    (st.pwr != PWR_ACTIVE) |-> !O_DQ_OE && !O_DQS_OE)
    else $error("drivers on while clocks stopped");
  a_pd_kind: assert property (
    $changed(st.pwr) && st.pwr == PWR_ACT_PD
      |-> $past(st.open_banks) != `DDP_NO_BANKS)
    else $error("active power-down with all banks idle");
  a_sr_exit_async: assert property (
    st.pwr == PWR_SELF_REF && st.s2.cke |=> st.pwr == PWR_ACTIVE)
    else $error("self refresh exit missed");
  a_pd_no_cmd: assert property (
    $past(st.pwr) != PWR_ACTIVE |-> !st.cmd_v)
    else $error("command accepted in power-down");
  a_sr_no_odt: assert property (
    st.pwr == PWR_SELF_REF ##1 st.pwr == PWR_SELF_REF |-> !st.odt_q)
    else $error("termination sampled in self refresh");
  a_term_off: assert property (
    !rtt_on |-> !O_TERM_EN)
    else $error("termination on while disabled");
  a_mask_drop: assert property (
    st.wr_beat && $past(st.s2.dm) && !rdqs_mode |-> !st.wr_we)
    else $error("masked write beat stored");
  a_pre_all: assert property (
    st.cmd_v && st.code == `DDP_CODE_PRE && st.auto_pre
      |-> st.open_banks == `DDP_NO_BANKS)
    else $error("precharge all left a bank open");
  a_emr_load: assert property (
    st.cmd_v && st.code == `DDP_CODE_MRS && st.bank == `DDP_SEL_EMR
      |-> st.emr == st.row)
    else $error("extended mode register not loaded");

  c_self_ref: cover property (
    st.pwr == PWR_ACTIVE ##1 st.pwr == PWR_SELF_REF);
  c_act_pd: cover property (
    st.pwr == PWR_ACTIVE ##1 st.pwr == PWR_ACT_PD);
  c_masked_beat: cover property (st.wr_beat && !st.wr_we);
  c_read_beat: cover property (st.rd_req ##[1:200] st.rd_req);

endmodule : ddp_top
